/* File: rtl/hbp_pkg.sv */
//////////////////////////////////////////////////////////////////
// Purpose: shared constants and types of the host bus port
// Assumes: two channels, eight-bit register data
// Notes: channel index 0 is channel A, index 1 is channel B
//////////////////////////////////////////////////////////////////
package hbp_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 16;
	localparam int TX_FIFO_DEPTH = 4;
	localparam int RX_FIFO_DEPTH = 8;
	localparam int CHAN_A = 0;
	localparam int CHAN_B = 1;

	// ****************************************************************
	// register indices
	// ****************************************************************
	localparam logic [3:0] REG_COMMAND = 4'h0;
	localparam logic [3:0] REG_STATUS1 = 4'h1;
	localparam logic [3:0] REG_VECTOR = 4'h2;
	localparam logic [3:0] REG_PENDING = 4'h3;
	localparam logic [3:0] REG_MODE4 = 4'h4;
	localparam logic [3:0] REG_MODE5 = 4'h5;
	localparam logic [3:0] REG_FRAME_LOW = 4'h6;
	localparam logic [3:0] REG_SYNC_FLAG = 4'h7;
	localparam logic [3:0] REG_FIFO_PORT = 4'h8;
	localparam logic [3:0] REG_MASTER_INT = 4'h9;
	localparam logic [3:0] REG_MISC10 = 4'hA;
	localparam logic [3:0] REG_CLOCK_MODE = 4'hB;
	localparam logic [3:0] REG_DIVISOR_LOW = 4'hC;
	localparam logic [3:0] REG_DIVISOR_HIGH = 4'hD;
	localparam logic [3:0] REG_MISC14 = 4'hE;
	localparam logic [3:0] REG_EXT_INT_CTRL = 4'hF;

	// ****************************************************************
	// field positions and codes
	// ****************************************************************
	localparam int EIC_ENH_ACCESS_BIT = 0;
	localparam int EIC_FRAME_COUNT_BIT = 2;
	localparam int ENH_MIRROR_BIT = 6;
	localparam logic [2:0] POINT_HIGH_CODE = 3'h1;
	localparam int MUX_CHAN_BIT = 4;

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [7:0] ENH_RESET = 8'h00;
	localparam logic [3:0] POINTER_RESET = 4'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACCESS = 3'b010,
		ST_RESET = 3'b100
	} bus_state_type;

	typedef struct packed {
		logic [7:0] rr0;
		logic [7:0] rr1;
		logic [7:0] rr10;
		logic [7:0] frame_low;
		logic [7:0] frame_high;
	} chan_status_type;

	typedef struct packed {
		logic active;
		logic read;
		logic chan_b;
		logic [3:0] regsel;
	} access_type;

endpackage

/* File: rtl/byte_fifo.sv */
//////////////////////////////////////////////////////////////////
// Purpose: small first-in first-out store for channel data bytes
// Assumes: depth is a power of two, at least two
// Notes: push when full and pop when empty are ignored
//////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic full,
	output logic empty
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("byte_fifo depth must be a power of two of at least two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	wire do_push = push & ~full;
	wire do_pop = pop & ~empty;
	wire [PW:0] next_count = count + (PW+1)'(do_push) - (PW+1)'(do_pop);

	assign head = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			full <= 1'b0;
			empty <= 1'b1;
		end else if (clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			full <= 1'b0;
			empty <= 1'b1;
		end else begin
			wr_ptr <= wr_ptr + PW'(do_push);
			rd_ptr <= rd_ptr + PW'(do_pop);
			count <= next_count;
			full <= next_count == (PW+1)'(DEPTH);
			empty <= next_count == '0;
		end
	end
endmodule

/* File: rtl/host_bus_port.sv */
//////////////////////////////////////////////////////////////////
// Purpose: host parallel bus port of a two-channel serial controller
// Assumes: all inputs synchronous to clk_sys; bus_mux_mode static
// Notes: serves the plain strobe bus and the multiplexed bus
//////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module host_bus_port import hbp_pkg::*; #(
	parameter int TX_DEPTH = TX_FIFO_DEPTH,
	parameter int RX_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic bus_mux_mode,
	input wire logic chip_enable_n,
	input wire logic read_strobe_n,
	input wire logic store_strobe_n,
	input wire logic chan_a_select,
	input wire logic data_select,
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe,
	input wire logic [7:0] shared_addr_data_bus_in,
	output logic [7:0] shared_addr_data_bus_out,
	output logic shared_addr_data_bus_oe,
	input wire logic addr_latch_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic first_chip_select_n,
	input wire logic second_chip_select,
	input wire logic int_ack_strobe_n,
	input wire logic int_enable_in,
	input wire logic int_requesting,
	input wire logic [2:0] vector_status,
	input wire logic [7:0] int_pending_bits,
	input chan_status_type [1:0] chan_status,
	input wire logic [1:0] rx_push,
	input wire logic [1:0][7:0] rx_byte,
	output logic [1:0] rx_fifo_full,
	output logic [1:0] rx_fifo_empty,
	input wire logic [1:0] tx_pop,
	output logic [1:0][7:0] tx_byte,
	output logic [1:0] tx_byte_valid,
	output logic [1:0] tx_fifo_full,
	output logic [1:0] tx_fifo_empty,
	output logic [1:0][15:0][7:0] write_regs,
	output logic [1:0][7:0] enh_regs,
	output logic bus_reset_pulse
);
	if (TX_DEPTH != TX_FIFO_DEPTH || RX_DEPTH != RX_FIFO_DEPTH) begin : g_chk
		$error("host_bus_port fifo depths are fixed by the register map");
	end

	// ****************************************************************
	// read value selection
	// ****************************************************************
	function automatic logic [7:0] read_value(
		input logic [3:0] r,
		input logic [15:0][7:0] regs,
		input logic [7:0] enh,
		input chan_status_type st,
		input logic [7:0] vec,
		input logic [7:0] pend,
		input logic [7:0] rx_head
	);
		logic mirror;
		logic fcnt;
		logic [7:0] eic;
		mirror = enh[ENH_MIRROR_BIT];
		eic = regs[REG_EXT_INT_CTRL];
		fcnt = eic[EIC_FRAME_COUNT_BIT];
		unique case (r)
			REG_COMMAND: read_value = st.rr0;
			REG_STATUS1: read_value = st.rr1;
			REG_VECTOR: read_value = vec;
			REG_PENDING: read_value = pend;
			REG_MODE4: read_value = mirror ? regs[REG_MODE4] : st.rr0;
			REG_MODE5: read_value = mirror ? regs[REG_MODE5] : st.rr1;
			REG_FRAME_LOW: read_value = fcnt ? st.frame_low : vec;
			REG_SYNC_FLAG: read_value = fcnt ? st.frame_high : pend;
			REG_FIFO_PORT: read_value = rx_head;
			REG_MASTER_INT: read_value = mirror ? regs[REG_MASTER_INT] :
				regs[REG_DIVISOR_HIGH];
			REG_MISC10: read_value = st.rr10;
			REG_CLOCK_MODE: read_value = mirror ? regs[REG_CLOCK_MODE] : eic;
			REG_DIVISOR_LOW: read_value = regs[REG_DIVISOR_LOW];
			REG_DIVISOR_HIGH: read_value = regs[REG_DIVISOR_HIGH];
			REG_MISC14: read_value = mirror ? regs[REG_MISC14] : st.rr10;
			REG_EXT_INT_CTRL: read_value = eic;
		endcase
	endfunction

	// ****************************************************************
	// bus decode
	// ****************************************************************
	bus_state_type state;
	bus_state_type next_state;
	logic [1:0][3:0] pointer;
	logic [7:0] latched_addr;
	logic addr_cs_ok;
	logic addr_strobe_q;
	logic int_ack_q;
	logic [1:0][7:0] rx_head;

	// plain bus
	wire plain_rd = ~chip_enable_n & ~read_strobe_n;
	wire plain_wr = ~chip_enable_n & ~store_strobe_n;
	wire plain_reset = ~read_strobe_n & ~store_strobe_n;
	wire plain_chan_b = ~chan_a_select;
	wire [3:0] plain_reg = data_select ? REG_FIFO_PORT :
		pointer[plain_chan_b];

	// multiplexed bus
	wire addr_rise = ~addr_latch_strobe_n & 1'b0 | (addr_strobe_q == 1'b0 &&
		addr_latch_strobe_n == 1'b1);
	wire mux_sel = ~data_strobe_n & addr_cs_ok & second_chip_select;
	wire mux_reset = ~addr_latch_strobe_n & ~data_strobe_n;
	wire mux_chan_b = ~latched_addr[MUX_CHAN_BIT];
	wire [3:0] mux_reg = latched_addr[3:0];

	access_type acc;
	assign acc.active = bus_mux_mode ? mux_sel : (plain_rd | plain_wr);
	assign acc.read = bus_mux_mode ? read_not_write : plain_rd;
	assign acc.chan_b = bus_mux_mode ? mux_chan_b : plain_chan_b;
	assign acc.regsel = bus_mux_mode ? mux_reg : plain_reg;

	wire reset_req = bus_mux_mode ? mux_reset : plain_reset;
	wire strobe_rd = bus_mux_mode ? (~data_strobe_n & read_not_write) :
		~read_strobe_n;
	wire strobe_any = bus_mux_mode ? ~data_strobe_n :
		(~read_strobe_n | ~store_strobe_n);
	wire [7:0] wdata = bus_mux_mode ? shared_addr_data_bus_in :
		host_data_bus_in;
	wire ack_read = ~int_ack_q & strobe_rd & int_enable_in &
		int_requesting;
	wire start = state == ST_IDLE && !reset_req;
	wire commit = start & ~ack_read & int_ack_q & acc.active;
	wire ack_start = start & ack_read;
	wire do_write = commit & ~acc.read;
	wire do_read = commit & acc.read;

	// ****************************************************************
	// write target decode
	// ****************************************************************
	wire ch = acc.chan_b;
	wire [7:0] eic_sel = write_regs[ch][REG_EXT_INT_CTRL];
	wire enh_target = acc.regsel == REG_SYNC_FLAG &&
		eic_sel[EIC_ENH_ACCESS_BIT];
	wire shared_target = acc.regsel == REG_VECTOR ||
		acc.regsel == REG_MASTER_INT;
	wire fifo_target = acc.regsel == REG_FIFO_PORT;
	wire cmd_access = commit & ~bus_mux_mode & ~data_select;
	wire [3:0] new_pointer = {wdata[5:3] == POINT_HIGH_CODE, wdata[2:0]};

	wire [7:0] vec_plain = write_regs[CHAN_A][REG_VECTOR];
	wire [7:0] vec_mod = {vec_plain[7:4], vector_status, vec_plain[0]};
	wire [7:0] vec_read = ch ? vec_mod : vec_plain;
	wire [7:0] pend_read = ch ? 8'h00 : int_pending_bits;
	wire [7:0] rd_value = read_value(acc.regsel, write_regs[ch],
		enh_regs[ch], chan_status[ch], vec_read, pend_read, rx_head[ch]);

	wire [1:0] tx_push;
	wire [1:0] rx_pop;
	wire [1:0][7:0] tx_head;
	wire [1:0] tx_full_w;
	wire [1:0] tx_empty_w;
	wire [1:0] rx_full_w;
	wire [1:0] rx_empty_w;
	wire soft_clear = state != ST_RESET && reset_req;

	// ****************************************************************
	// access sequencing
	// ****************************************************************
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (reset_req) begin
					next_state = ST_RESET;
				end else if (ack_read || commit) begin
					next_state = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (reset_req) begin
					next_state = ST_RESET;
				end else if (!strobe_any) begin
					next_state = ST_IDLE;
				end
			end
			ST_RESET: begin
				if (!reset_req) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			addr_strobe_q <= 1'b1;
			int_ack_q <= 1'b1;
			bus_reset_pulse <= 1'b0;
		end else begin
			state <= next_state;
			addr_strobe_q <= addr_latch_strobe_n;
			int_ack_q <= int_ack_strobe_n;
			bus_reset_pulse <= soft_clear;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latched_addr <= 8'h00;
			addr_cs_ok <= 1'b0;
		end else if (addr_rise) begin
			latched_addr <= shared_addr_data_bus_in;
			addr_cs_ok <= ~first_chip_select_n;
		end
	end

	// ****************************************************************
	// read data and bus drive
	// ****************************************************************
	wire drive_next = next_state == ST_ACCESS &&
		(state == ST_ACCESS ? host_data_bus_oe | shared_addr_data_bus_oe :
		(do_read | ack_start));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			host_data_bus_out <= 8'h00;
			shared_addr_data_bus_out <= 8'h00;
			host_data_bus_oe <= 1'b0;
			shared_addr_data_bus_oe <= 1'b0;
		end else begin
			if (ack_start) begin
				host_data_bus_out <= vec_mod;
				shared_addr_data_bus_out <= vec_mod;
			end else if (do_read) begin
				host_data_bus_out <= rd_value;
				shared_addr_data_bus_out <= rd_value;
			end
			host_data_bus_oe <= drive_next & ~bus_mux_mode;
			shared_addr_data_bus_oe <= drive_next & bus_mux_mode;
		end
	end

	// ****************************************************************
	// register set
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			write_regs <= {2 * REG_COUNT{WREG_RESET}};
			enh_regs <= {2{ENH_RESET}};
			pointer <= {2{POINTER_RESET}};
		end else if (soft_clear) begin
			write_regs <= {2 * REG_COUNT{WREG_RESET}};
			enh_regs <= {2{ENH_RESET}};
			pointer <= {2{POINTER_RESET}};
		end else begin
			if (do_write && enh_target) begin
				enh_regs[ch] <= wdata;
			end else if (do_write && shared_target) begin
				write_regs[CHAN_A][acc.regsel] <= wdata;
				write_regs[CHAN_B][acc.regsel] <= wdata;
			end else if (do_write && !fifo_target) begin
				write_regs[ch][acc.regsel] <= wdata;
			end
			if (cmd_access) begin
				if (!acc.read && acc.regsel == REG_COMMAND) begin
					pointer[ch] <= new_pointer;
				end else begin
					pointer[ch] <= POINTER_RESET;
				end
			end
		end
	end

	// ****************************************************************
	// channel fifos
	// ****************************************************************
	for (genvar c = 0; c < 2; c++) begin : g_chan
		assign tx_push[c] = do_write & fifo_target & (ch == c[0]);
		assign rx_pop[c] = do_read & fifo_target & (ch == c[0]);

		byte_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_tx (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.clear(soft_clear),
			.push(tx_push[c]),
			.push_data(wdata),
			.pop(tx_pop[c]),
			.head(tx_head[c]),
			.full(tx_full_w[c]),
			.empty(tx_empty_w[c])
		);

		byte_fifo #(.WIDTH(DATA_W), .DEPTH(RX_DEPTH)) u_rx (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.clear(soft_clear),
			.push(rx_push[c]),
			.push_data(rx_byte[c]),
			.pop(rx_pop[c]),
			.head(rx_head[c]),
			.full(rx_full_w[c]),
			.empty(rx_empty_w[c])
		);

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				tx_byte[c] <= 8'h00;
				tx_byte_valid[c] <= 1'b0;
			end else begin
				tx_byte_valid[c] <= tx_pop[c] & ~tx_empty_w[c];
				if (tx_pop[c] && !tx_empty_w[c]) begin
					tx_byte[c] <= tx_head[c];
				end
			end
		end
	end

	assign tx_fifo_full = tx_full_w;
	assign tx_fifo_empty = tx_empty_w;
	assign rx_fifo_full = rx_full_w;
	assign rx_fifo_empty = rx_empty_w;
endmodule

/* File: rtl/_unused_placeholder_removed.sv */
`timescale 1ns/1ps

/* File: bench/host_bus_port_checker.sv */
// Purpose: port assertions of the host bus port
// Assumes: one clock domain, reset asynchronous and active low
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
module host_bus_port_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic bus_mux_mode,
	input wire logic chip_enable_n,
	input wire logic read_strobe_n,
	input wire logic store_strobe_n,
	input wire logic addr_latch_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic second_chip_select,
	input wire logic host_data_bus_oe,
	input wire logic shared_addr_data_bus_oe,
	input wire logic [1:0] tx_pop,
	input wire logic [1:0] tx_fifo_empty,
	input wire logic [1:0] tx_byte_valid,
	input wire logic [1:0][15:0][7:0] write_regs,
	input wire logic [1:0][7:0] enh_regs,
	input wire logic bus_reset_pulse
);
	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	wire plain_rst = !bus_mux_mode && !read_strobe_n && !store_strobe_n;
	wire mux_rst = bus_mux_mode && !addr_latch_strobe_n && !data_strobe_n;

	a_read_drives_bus: assert property ($rose(host_data_bus_oe) |->
		!$past(read_strobe_n) && $past(store_strobe_n))
		else $error("plain bus driven without a read");
	a_read_releases_bus: assert property (read_strobe_n &&
		$past(read_strobe_n) |-> !host_data_bus_oe)
		else $error("plain bus not released");
	a_mux_read_drives: assert property ($rose(shared_addr_data_bus_oe) |->
		!$past(data_strobe_n) && $past(read_not_write))
		else $error("shared bus driven without a read");
	a_plain_strobe_reset: assert property (plain_rst &&
		!$past(plain_rst) |=> bus_reset_pulse)
		else $error("strobe reset not seen");
	a_mux_strobe_reset: assert property (mux_rst &&
		!$past(mux_rst) |=> bus_reset_pulse)
		else $error("address and data strobe reset not seen");
	a_pulse_has_cause: assert property (bus_reset_pulse |->
		$past(plain_rst) || $past(mux_rst))
		else $error("reset pulse without cause");
	a_reset_clears_regs: assert property (bus_reset_pulse |->
		write_regs == '0 && enh_regs == '0 && tx_fifo_empty == 2'h3)
		else $error("registers not cleared by reset");
	a_unselected_no_write: assert property (!bus_mux_mode &&
		chip_enable_n && (read_strobe_n || store_strobe_n)
		|=> $stable(write_regs))
		else $error("write while not selected");
	a_cs1_low_no_write: assert property (bus_mux_mode &&
		!second_chip_select && addr_latch_strobe_n |=> $stable(write_regs))
		else $error("write while second select low");
	a_tx_pop_valid: assert property (tx_byte_valid[0] |->
		$past(tx_pop[0]) && !$past(tx_fifo_empty[0]))
		else $error("transmit byte without pop");
	c_reset: cover property (bus_reset_pulse);
	c_plain_read: cover property ($rose(host_data_bus_oe));
	c_mux_read: cover property ($rose(shared_addr_data_bus_oe));
endmodule

/* File: bench/cpu_bus_model.sv */
// Purpose: microprocessor bus master for both bus variants
// Assumes: requests change just after a rising edge
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic clk_sys,
	output logic chip_enable_n,
	output logic read_strobe_n,
	output logic store_strobe_n,
	output logic chan_a_select,
	output logic data_select,
	output logic [7:0] host_data_bus_in,
	input wire logic [7:0] host_data_bus_out,
	input wire logic host_data_bus_oe,
	output logic [7:0] shared_addr_data_bus_in,
	input wire logic [7:0] shared_addr_data_bus_out,
	input wire logic shared_addr_data_bus_oe,
	output logic addr_latch_strobe_n,
	output logic data_strobe_n,
	output logic read_not_write,
	output logic first_chip_select_n,
	output logic second_chip_select,
	output logic int_ack_strobe_n
);
	// ****************************************************************
	// bus cycles
	// ****************************************************************
	logic drive = 1'b0;
	logic [7:0] mdata = 8'h00;
	logic [7:0] last = 8'h00;
	assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out :
		drive ? mdata : ~last;
	assign shared_addr_data_bus_in = shared_addr_data_bus_oe ?
		shared_addr_data_bus_out : drive ? mdata : ~last;
	initial begin
		{chip_enable_n, read_strobe_n, store_strobe_n, addr_latch_strobe_n,
			data_strobe_n, first_chip_select_n, int_ack_strobe_n} = 7'h7F;
		{chan_a_select, data_select, read_not_write} = 3'h0;
		second_chip_select = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (drive)
			last <= mdata;
	end
	task automatic plain_cycle(input logic rd, input logic sel,
		input logic ack, input logic chan_a, input logic dsel,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		int_ack_strobe_n <= !ack;
		if (ack)
			@(posedge clk_sys);
		chip_enable_n <= !sel;
		chan_a_select <= chan_a;
		data_select <= dsel;
		read_strobe_n <= !rd;
		store_strobe_n <= rd;
		drive <= !rd;
		mdata <= d;
		@(posedge clk_sys);
		for (int i = 0; i < 4 && rd && host_data_bus_oe !== 1'b1; i++)
			@(posedge clk_sys);
		q = (host_data_bus_oe === 1'b1) ? host_data_bus_out : 8'hXX;
		{chip_enable_n, read_strobe_n, store_strobe_n} <= 3'h7;
		int_ack_strobe_n <= 1'b1;
		drive <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic mux_cycle(input logic rd, input logic cs_ok,
		input logic cs1, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		second_chip_select <= cs1;
		first_chip_select_n <= !cs_ok;
		addr_latch_strobe_n <= 1'b0;
		drive <= 1'b1;
		mdata <= a;
		@(posedge clk_sys);
		addr_latch_strobe_n <= 1'b1;
		@(posedge clk_sys);
		first_chip_select_n <= 1'b1;
		read_not_write <= rd;
		drive <= !rd;
		mdata <= d;
		data_strobe_n <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 4 && rd && shared_addr_data_bus_oe !== 1'b1; i++)
			@(posedge clk_sys);
		q = (shared_addr_data_bus_oe === 1'b1) ? shared_addr_data_bus_out :
			8'hXX;
		data_strobe_n <= 1'b1;
		second_chip_select <= 1'b0;
		drive <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic strobe_reset(input logic mux);
		@(posedge clk_sys);
		if (mux)
			{addr_latch_strobe_n, data_strobe_n} <= 2'h0;
		else
			{read_strobe_n, store_strobe_n} <= 2'h0;
		repeat (2) @(posedge clk_sys);
		{addr_latch_strobe_n, data_strobe_n} <= 2'h3;
		{read_strobe_n, store_strobe_n} <= 2'h3;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule

/* File: bench/host_bus_port_tb.sv */
// Purpose: self-checking bench of the host bus port
// Assumes: cpu_bus_model drives the host side of the port
// Notes: plain bus runs first, the multiplexed bus after a reset
`timescale 1ns/1ps
module host_bus_port_tb import hbp_pkg::*;;
	// ****************************************************************
	// harness
	// ****************************************************************
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic bus_mux_mode = 1'b0;
	wire chip_enable_n, read_strobe_n, store_strobe_n, chan_a_select;
	wire data_select, addr_latch_strobe_n, data_strobe_n, read_not_write;
	wire first_chip_select_n, second_chip_select, int_ack_strobe_n;
	wire [7:0] host_data_bus_in, shared_addr_data_bus_in;
	logic [7:0] host_data_bus_out, shared_addr_data_bus_out, q;
	logic host_data_bus_oe, shared_addr_data_bus_oe, bus_reset_pulse;
	logic int_enable_in = 1'b0;
	logic int_requesting = 1'b0;
	logic [2:0] vector_status = 3'h5;
	logic [7:0] int_pending_bits = 8'h00;
	chan_status_type [1:0] chan_status = {10{8'hC3}};
	logic [1:0] rx_push = 2'h0;
	logic [1:0][7:0] rx_byte = 16'h0000;
	logic [1:0] tx_pop = 2'h0;
	logic [1:0][7:0] tx_byte;
	logic [1:0] tx_byte_valid, tx_fifo_full, tx_fifo_empty;
	logic [1:0] rx_fifo_full, rx_fifo_empty;
	logic [1:0][15:0][7:0] write_regs;
	logic [1:0][7:0] enh_regs;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int pulses = 0;
	host_bus_port u_host_bus_port (.*);
	cpu_bus_model u_cpu_bus_model (.*);
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (bus_reset_pulse === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic pw(input logic a, input logic dsel, input logic [7:0] d);
		u_cpu_bus_model.plain_cycle(1'b0, 1'b1, 1'b0, a, dsel, d, q);
	endtask
	task automatic pr(input logic a, input logic dsel);
		u_cpu_bus_model.plain_cycle(1'b1, 1'b1, 1'b0, a, dsel, 8'h00, q);
	endtask
	task automatic mw(input logic [7:0] a, input logic [7:0] d);
		u_cpu_bus_model.mux_cycle(1'b0, 1'b1, 1'b1, a, d, q);
	endtask
	task automatic mr(input logic [7:0] a);
		u_cpu_bus_model.mux_cycle(1'b1, 1'b1, 1'b1, a, 8'h00, q);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_pointer();
		pw(1'b1, 1'b0, 8'h0C);
		pw(1'b1, 1'b0, 8'h5A);
		check("wr12a", write_regs[0][12], 8'h5A);
		check("wr12b", write_regs[1][12], 8'h00);
		pw(1'b1, 1'b0, 8'h0C);
		pr(1'b1, 1'b0);
		check("rd12a", q, 8'h5A);
		pw(1'b1, 1'b0, 8'h30);
		check("wr0a", write_regs[0][0], 8'h30);
		pw(1'b0, 1'b0, 8'h0D);
		pw(1'b0, 1'b0, 8'hA5);
		check("wr13b", write_regs[1][13], 8'hA5);
		$display("test_pointer done");
	endtask
	task automatic test_tx();
		for (int i = 1; i <= 5; i++)
			pw(1'b1, 1'b1, 8'(i * 8'h11));
		check("txfull", tx_fifo_full[0], 1'b1);
		check("txb", tx_fifo_empty[1], 1'b1);
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk_sys);
			tx_pop <= 2'h1;
			@(posedge clk_sys);
			tx_pop <= 2'h0;
			#1;
			check("txbyte", {tx_byte_valid[0], tx_byte[0]}, {1'b1, 8'(i * 8'h11)});
		end
		check("txempty", tx_fifo_empty[0], 1'b1);
		$display("test_tx done");
	endtask
	task automatic test_rx();
		for (int i = 1; i <= 3; i++) begin
			@(posedge clk_sys);
			rx_push <= 2'h2;
			rx_byte[1] <= 8'(i * 8'h21);
			@(posedge clk_sys);
			rx_push <= 2'h0;
		end
		for (int i = 1; i <= 3; i++) begin
			pr(1'b0, 1'b1);
			check("rxbyte", q, 8'(i * 8'h21));
		end
		check("rxempty", rx_fifo_empty[1], 1'b1);
		$display("test_rx done");
	endtask
	task automatic test_select();
		u_cpu_bus_model.plain_cycle(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h99, q);
		check("cewr", tx_fifo_empty[0], 1'b1);
		u_cpu_bus_model.plain_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, q);
		check("cerd", q, 8'hXX);
		$display("test_select done");
	endtask
	task automatic test_ack();
		pw(1'b1, 1'b0, 8'h02);
		pw(1'b1, 1'b0, 8'hF0);
		check("vecb", write_regs[1][2], 8'hF0);
		int_enable_in <= 1'b1;
		int_requesting <= 1'b1;
		u_cpu_bus_model.plain_cycle(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
		check("ackvec", q, 8'hFA);
		int_enable_in <= 1'b0;
		u_cpu_bus_model.plain_cycle(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
		check("acklow", q, 8'hXX);
		$display("test_ack done");
	endtask
	task automatic test_mux();
		mw(8'h1C, 8'h77);
		check("mwr", write_regs[0][12], 8'h77);
		mr(8'h1C);
		check("mrd", q, 8'h77);
		u_cpu_bus_model.mux_cycle(1'b0, 1'b0, 1'b1, 8'h0C, 8'h66, q);
		check("cs0", write_regs[1][12], 8'h00);
		u_cpu_bus_model.mux_cycle(1'b0, 1'b1, 1'b0, 8'h0C, 8'h66, q);
		check("cs1", write_regs[1][12], 8'h00);
		mw(8'h0C, 8'h66);
		check("mchb", write_regs[1][12], 8'h66);
		$display("test_mux done");
	endtask
	task automatic test_enh();
		mr(8'h14);
		check("rr0", q, 8'hC3);
		mr(8'h16);
		check("nofrm", q, 8'h00);
		mw(8'h14, 8'h9C);
		mw(8'h1F, 8'h05);
		mw(8'h17, 8'h40);
		check("enh", {enh_regs[0], write_regs[0][7]}, 16'h4000);
		mr(8'h14);
		check("mirror", q, 8'h9C);
		mr(8'h16);
		check("frame", q, 8'hC3);
		$display("test_enh done");
	endtask
	task automatic test_reset(input logic mux);
		int p;
		p = pulses;
		u_cpu_bus_model.strobe_reset(mux);
		check("pulse", 16'(pulses - p), 16'h0001);
		check("regs", 16'(|write_regs), 16'h0000);
		$display("test_reset done");
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		test_pointer();
		test_tx();
		test_rx();
		test_select();
		test_ack();
		test_reset(1'b0);
		rst_n <= 1'b0;
		bus_mux_mode <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		test_mux();
		test_enh();
		test_reset(1'b1);
		print_verdict();
	end
endmodule
bind host_bus_port host_bus_port_checker u_chk (.*);
